// ===== hw/dsl_core.sv
`timescale 1ns/10ps
`include "dsl_defines.svh"
module dsl_core #(
    parameter int WORD_BITS = `DSL_WORD_BITS,
    parameter int FIFO_DEPTH = `DSL_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Serial port, sampled in the core clock
    input wire logic sclk,
    input wire logic frame_sel_n,
    input wire logic sdi,
    // Load strobe and variant controls
    input wire logic load_strobe_n,
    input wire dsl_pkg::dsl_load_mode_t load_mode,
    input wire logic address_select_pin,
    // Results
    output logic [`DSL_CODE_BITS-1:0] dac_code,
    output logic ref_out_en,
    output logic [6:0] bus_address,
    output logic word_overrun
);
    import dsl_pkg::*;
    // Only the 24-bit word layout is served
    if (WORD_BITS != `DSL_WORD_BITS) begin : g_bad_width
        $error("dsl_core serves 24-bit words only");
    end

    // ----------------------------------------
    // Serial shift
    // ----------------------------------------
    logic sclk_d_r;
    logic [WORD_BITS-1:0] shift_r;
    logic [`DSL_CNT_BITS-1:0] cnt_r;
    dsl_state_t state_r;
    logic fall;
    logic word_valid_r;
    logic [WORD_BITS-1:0] word_r;
    logic fifo_ready;
    assign fall = sclk_d_r && !sclk;

    // Clock edge detect
    always_ff @(posedge core_clk) begin
        // Low after reset so no false falling edge follows reset
        if (!rst_n) sclk_d_r <= 1'b0;
        else sclk_d_r <= sclk;
    end

    // Shift on falling serial edge while framed
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= DSL_ST_IDLE;
            cnt_r <= '0;
            shift_r <= '0;
        end else if (frame_sel_n) begin
            state_r <= DSL_ST_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                DSL_ST_IDLE: begin
                    state_r <= DSL_ST_SHIFT;
                    if (fall) begin
                        shift_r <= {shift_r[WORD_BITS-2:0], sdi};
                        cnt_r <= `DSL_CNT_BITS'(1);
                    end
                end
                DSL_ST_SHIFT: begin
                    if (fall) begin
                        shift_r <= {shift_r[WORD_BITS-2:0], sdi};
                        if (cnt_r == `DSL_CNT_BITS'(WORD_BITS - 1)) begin
                            state_r <= DSL_ST_DONE;
                        end
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                DSL_ST_DONE: state_r <= DSL_ST_DONE;
                default: state_r <= DSL_ST_IDLE;
            endcase
        end
    end

    // Word strobe into the FIFO, held until accepted
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            word_valid_r <= 1'b0;
            word_r <= '0;
            word_overrun <= 1'b0;
        end else begin
            if (word_valid_r && fifo_ready) word_valid_r <= 1'b0;
            if (!frame_sel_n && state_r == DSL_ST_SHIFT && fall &&
                cnt_r == `DSL_CNT_BITS'(WORD_BITS - 1)) begin
                if (word_valid_r && !fifo_ready) begin
                    word_overrun <= 1'b1; // Word dropped, FIFO full
                end else begin
                    word_valid_r <= 1'b1;
                    word_r <= {shift_r[WORD_BITS-2:0], sdi};
                end
            end
        end
    end

    // ----------------------------------------
    // Word buffer
    // ----------------------------------------
    logic f_valid;
    logic f_ready;
    logic [WORD_BITS-1:0] f_data;
    dsl_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(word_valid_r),
        .in_ready(fifo_ready),
        .in_data(word_r),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // ----------------------------------------
    // Input, DAC and control registers
    // ----------------------------------------
    dsl_word_t w;
    logic [`DSL_CODE_BITS-1:0] input_r;
    logic pending_r;
    logic load_strobe_n_d_r;
    logic [`DSL_CTRL_BITS-1:0] ctrl_r;
    logic load_now;
    logic pend_hold;
    assign w = dsl_word_t'(f_data);
    // Hold the drain while a loaded word waits with the strobe high, and in
    // the cycle that loads it, so in async mode the waiting word reaches the DAC first
    assign pend_hold = pending_r && (load_strobe_n || load_now);
    assign f_ready = !pend_hold;

    // Rising strobe ends a pulse; sync mode loads there, async on fall
    always_comb begin
        if (load_mode == DSL_LOAD_SYNC)
            load_now = !load_strobe_n_d_r && load_strobe_n;
        else
            load_now = load_strobe_n_d_r && !load_strobe_n;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) load_strobe_n_d_r <= 1'b1;
        else load_strobe_n_d_r <= load_strobe_n;
    end

    // Input register captures the code field of each word
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            input_r <= `DSL_CODE_ZERO;
            pending_r <= 1'b0;
        end else if (f_valid && f_ready) begin
            input_r <= w.code;
            pending_r <= load_strobe_n;
        end else if (load_now && pending_r) begin
            pending_r <= 1'b0;
        end
    end

    // DAC register update
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dac_code <= `DSL_CODE_ZERO;
        end else if (f_valid && f_ready && !load_strobe_n) begin
            dac_code <= w.code;
        end else if (load_now && pending_r) begin
            dac_code <= input_r;
        end
    end

    // Control register and reference direction
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r <= `DSL_CTRL_DEFAULT;
            ref_out_en <= 1'b1;
        end else begin
            ref_out_en <= !ctrl_r[`DSL_CTRL_REF_OFF_BIT];
        end
    end

    // Bus address follows the select pin one clock later
    always_ff @(posedge core_clk) begin
        if (!rst_n) bus_address <= `DSL_ADDR_BASE;
        else bus_address <= `DSL_ADDR_BASE | {6'h00, address_select_pin};
    end
endmodule // dsl_core

// ===== hw/dsl_defines.svh
// Function
// - Reset is level sensitive and active low, and while it is low every other pin is ignored.
// - Reset loads input and DAC registers with zero scale and the control register with defaults.
// - A low pulse on the load strobe copies the input register to the DAC register if it holds new data.
// - With the load strobe held low, each new input word updates the DAC register automatically.
// - In the two-wire variant the load strobe works in an asynchronous and a synchronous mode.
// - In the four-wire variant data is sampled on each falling serial clock edge into the shift register.
// - Frame select low starts a transfer and enables the clock, data and shift register.
// - In the two-wire variant one bus address bit follows the address pin live, without reset; here reset loads 7'h0c, clearing that bit.
// - After reset the reference pin acts as an output, the internal reference being enabled.
// - Each write carries a 24-bit word.
// - The DAC code is 10-bit straight binary with full scale all ones.
`ifndef DSL_DEFINES_SVH
`define DSL_DEFINES_SVH

`define DSL_WORD_BITS 24
`define DSL_CODE_BITS 10
`define DSL_CODE_LSB 6
`define DSL_CNT_BITS 5
`define DSL_CODE_ZERO 10'h000
`define DSL_CODE_FULL 10'h3ff
`define DSL_CTRL_BITS 4
`define DSL_CTRL_DEFAULT 4'h0
`define DSL_CTRL_REF_OFF_BIT 0
`define DSL_ADDR_BASE 7'h0c
`define DSL_FIFO_DEPTH 8

`endif

// ===== hw/dsl_pkg.sv
package dsl_pkg;
    `include "dsl_defines.svh"
    // One received serial word split into fields
    typedef struct packed {
        logic [3:0] cmd;
        logic [`DSL_CODE_BITS-1:0] code;
        logic [9:0] low;
    } dsl_word_t;
    typedef enum logic [1:0] {
        DSL_LOAD_ASYNC = 2'b00,
        DSL_LOAD_SYNC = 2'b01
    } dsl_load_mode_t;
    typedef enum logic [1:0] {
        DSL_ST_IDLE = 2'b00,
        DSL_ST_SHIFT = 2'b01,
        DSL_ST_DONE = 2'b10
    } dsl_state_t;
endpackage

// ===== hw/dsl_fifo.sv
`timescale 1ns/10ps
module dsl_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Wrap-around pointers need a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("dsl_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    logic push;
    logic pop;
    // Full and empty from pointer compare
    assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
    assign out_valid = wr_r != rd_r;
    assign out_data = mem_r[rd_r[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Pointers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) wr_r <= wr_r + 1'b1;
            if (pop) rd_r <= rd_r + 1'b1;
        end
    end
    // Storage
    always_ff @(posedge core_clk) begin
        if (push) mem_r[wr_r[AW-1:0]] <= in_data;
    end
endmodule // dsl_fifo

// ===== testbench/dsl_core_props.sv
`timescale 1ns/10ps
module dsl_core_props (
    // Clock
    input wire logic core_clk,
    input wire logic rst_n,
    // Pins
    input wire logic load_strobe_n,
    input wire logic address_select_pin,
    input wire logic [9:0] dac_code,
    input wire logic ref_out_en,
    input wire logic [6:0] bus_address,
    input wire logic word_overrun
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Strobe low now or lately
    sequence s_strobe;
        !load_strobe_n || !$past(load_strobe_n)
            || !$past(load_strobe_n, 2) || !$past(load_strobe_n, 3);
    endsequence
    AST_RST_CODE: assert property (disable iff (1'b0)
        !rst_n |=> dac_code == 10'h000) else $error("code");
    AST_RST_ADDR: assert property (disable iff (1'b0)
        !rst_n |=> bus_address == 7'h0c) else $error("addr");
    AST_RST_FLAG: assert property (disable iff (1'b0)
        !rst_n |=> !word_overrun) else $error("flag");
    AST_REF_OUT: assert property (1'b1 |-> ref_out_en)
        else $error("ref");
    AST_ADDR_LIVE: assert property (
        1'b1 |=> bus_address == {6'h06, $past(address_select_pin)})
        else $error("pin");
    AST_HOLD: assert property (
        load_strobe_n [*6] |-> $stable(dac_code)) else $error("hold");
    AST_CAUSE: assert property (
        $changed(dac_code) |-> s_strobe) else $error("cause");
    AST_STICKY: assert property (
        word_overrun |=> word_overrun) else $error("sticky");
endmodule // dsl_core_props

bind dsl_core dsl_core_props dsl_core_props_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load_strobe_n(load_strobe_n),
    .address_select_pin(address_select_pin),
    .dac_code(dac_code),
    .ref_out_en(ref_out_en),
    .bus_address(bus_address),
    .word_overrun(word_overrun)
);

// ===== testbench/dsl_host_model.sv
`timescale 1ns/10ps
module dsl_host_model (
    // Clock
    input wire logic core_clk,
    // Serial lines
    output logic sclk,
    output logic frame_sel_n,
    output logic sdi
);
    // Idle: frame off, clock parked
    initial begin
        sclk = 1'b0;
        frame_sel_n = 1'b1;
        sdi = 1'b0;
    end
    // Frame of n bits, MSB first
    task automatic send(input logic [23:0] w, input int n);
        @(negedge core_clk) frame_sel_n = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            @(negedge core_clk) sclk = 1'b1;
            @(negedge core_clk) sclk = 1'b0;
            sdi = w[i];
        end
        @(negedge core_clk) frame_sel_n = 1'b1;
        sdi = ~sdi; // Line flipped from the last bit, no stale bit
        @(negedge core_clk);
    endtask
endmodule // dsl_host_model

// ===== testbench/dsl_core_test.sv
`timescale 1ns/10ps
module dsl_core_test;
    import dsl_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, frame_sel_n, sdi, ref_out_en, word_overrun;
    logic load_strobe_n = 1'b1;
    dsl_load_mode_t load_mode = DSL_LOAD_ASYNC;
    logic address_select_pin = 1'b0;
    logic [9:0] dac_code;
    logic [9:0] last_code = 10'h000;
    logic [6:0] bus_address;
    logic [9:0] exp_q[$];
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    // Clock
    always #25 core_clk = ~core_clk;
    dsl_host_model dsl_host_model_inst (.core_clk(core_clk), .sclk(sclk),
        .frame_sel_n(frame_sel_n), .sdi(sdi));
    dsl_core dsl_core_inst (.core_clk(core_clk), .rst_n(rst_n),
        .sclk(sclk), .frame_sel_n(frame_sel_n), .sdi(sdi),
        .load_strobe_n(load_strobe_n), .load_mode(load_mode),
        .address_select_pin(address_select_pin), .dac_code(dac_code),
        .ref_out_en(ref_out_en), .bus_address(bus_address),
        .word_overrun(word_overrun));
    // Verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Compare a code
    task automatic chk_code(input logic [9:0] e, input logic [9:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    // Compare a status pin group
    task automatic chk_pin(input logic [6:0] e, input logic [6:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    // Send a word with code c, noting it if it should land
    task automatic put(input logic [9:0] c, input bit note);
        logic [23:0] w;
        w = $urandom();
        w[19:10] = c;
        if (note) exp_q.push_back(c);
        dsl_host_model_inst.send(w, 24);
    endtask
    // Oldest note against each DAC change
    always @(negedge core_clk) begin
        if (rst_n && dac_code !== last_code) begin
            if (exp_q.size() == 0) chk_code(last_code, dac_code);
            else chk_code(exp_q.pop_front(), dac_code);
        end
        last_code = dac_code;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end
    // Tests
    initial begin
        void'($urandom(21439));
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        chk_code(10'h000, dac_code);
        chk_pin(7'h01, {6'h00, ref_out_en});
        $display("reset test done");
        load_strobe_n = 1'b0;
        put(10'h3ff, 1);
        put({2'b10, 8'($urandom())}, 1);
        dsl_host_model_inst.send(24'hfffff0, 10);
        put(10'h0aa, 1);
        repeat (4) @(negedge core_clk);
        $display("auto load test done");
        for (int m = 0; m < 2; m++) begin
            load_strobe_n = 1'b1;
            load_mode = dsl_load_mode_t'(m);
            put(10'h101 + 10'(m), 0);
            repeat (8) @(negedge core_clk);
            exp_q.push_back(10'h101 + 10'(m));
            load_strobe_n = 1'b0;
            repeat (2) @(negedge core_clk);
            load_strobe_n = 1'b1;
            repeat (6) @(negedge core_clk);
        end
        $display("strobe mode test done");
        load_mode = DSL_LOAD_ASYNC;
        for (int i = 0; i < 11; i++) put(10'h1c0 + 10'(i), i < 10);
        chk_pin(7'h01, {6'h00, word_overrun});
        load_strobe_n = 1'b0;
        repeat (40) @(negedge core_clk);
        $display("buffer test done");
        repeat (2) begin
            address_select_pin = ~address_select_pin;
            repeat (2) @(negedge core_clk);
            chk_pin({6'h06, address_select_pin}, bus_address);
        end
        rst_n = 1'b0;
        dsl_host_model_inst.send(24'h0ffc00, 24);
        rst_n = 1'b1;
        chk_code(10'h000, dac_code);
        repeat (8) @(negedge core_clk);
        chk_code(10'h000, 10'(exp_q.size()));
        $display("reset in run test done");
        end_sim();
    end
endmodule // dsl_core_test
